/* include/ppps_pkg.sv */
// Purpose: Constants for the four parallel ports with pin sharing.
// Assumes: Byte-wide register port, one clock, active-low async reset.
// Notes:   Offsets are byte addresses within the 48-byte I/O block.
package ppps_pkg;
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 8;
  localparam logic [5:0]  REG_BLOCK_END = 6'h30;
  localparam logic [5:0]  OFS_A_LATCH   = 6'h00;
  localparam logic [5:0]  OFS_B_LATCH   = 6'h01;
  localparam logic [5:0]  OFS_C_LATCH   = 6'h02;
  localparam logic [5:0]  OFS_D_LATCH   = 6'h03;
  localparam logic [5:0]  OFS_A_DIR     = 6'h04;
  localparam logic [5:0]  OFS_B_DIR     = 6'h05;
  localparam logic [5:0]  OFS_C_DIR     = 6'h06;
  localparam logic [5:0]  OFS_D_DIR     = 6'h07;
  localparam logic [5:0]  OFS_PULSE_SEL = 6'h0a;
  localparam logic [5:0]  OFS_SYNC_SEL  = 6'h0b;
  localparam logic [7:0]  DIR_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;
  localparam logic [5:0]  PORT_B_MASK   = 6'h3f;
  // Field positions in the sync and serial select register
  localparam int          HSYNC_BIT     = 7;
  localparam int          VSYNC_BIT     = 6;
  localparam int          SCL_BIT       = 1;
  localparam int          SDA_BIT       = 0;
endpackage : ppps_pkg

/* logic/ppps_ports.sv */
// Purpose: Ports A to D with latches, direction registers and pin sharing.
// Assumes: Pins resolved outside; output enables are active low.
// Notes:   Port latches have no reset, so they power up unknown.
`timescale 1ns/1ps

// How it works
// - Direction one drives pin, zero is input
// - Reset clears every direction register
// - Direction registers are readable and writable
// - Output pins read back the latch
// - Input pin writes only load latch
// - Output pin writes load and drive
// - Input pins read the pin level
// - Both select registers reset to zero
// - Pulse select bit n takes C pin n
// - Serial enables take D pins 1, 0
// - Sync enables beat pulse on C7, C6
// - Registers decode in lowest 48 bytes
// - Reset leaves port latches untouched
// - Serial pins are open drain
module ppps_ports
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // Register port
  input  wire logic [ppps_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [ppps_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [ppps_pkg::DATA_W-1:0]   reg_rdata,
  // Port A pins
  input  wire logic [7:0]                    port_a_in,
  output logic      [7:0]                    port_a_out,
  output logic      [7:0]                    port_a_oe_n,
  // Port B pins
  input  wire logic [5:0]                    port_b_in,
  output logic      [5:0]                    port_b_out,
  output logic      [5:0]                    port_b_oe_n,
  // Port C pins
  input  wire logic [7:0]                    port_c_in,
  output logic      [7:0]                    port_c_out,
  output logic      [7:0]                    port_c_oe_n,
  // Port D pins
  input  wire logic [1:0]                    port_d_in,
  output logic      [1:0]                    port_d_out,
  output logic      [1:0]                    port_d_oe_n,
  // Pulse-width channels 8 to 15
  input  wire logic [7:0]                    pulse_out,
  // Sync processor outputs
  input  wire logic                          horiz_sync_out,
  input  wire logic                          vert_sync_out,
  // Two-wire serial bus: drive low requests
  input  wire logic                          serial_clk_pull,
  input  wire logic                          serial_data_pull,
  output logic                               serial_clk_in,
  output logic                               serial_data_in
);
  import ppps_pkg::*;

  logic [7:0] port_a_latch;
  logic [5:0] port_b_latch;
  logic [7:0] port_c_latch;
  logic [1:0] port_d_latch;
  logic [7:0] port_a_direction;
  logic [5:0] port_b_direction;
  logic [7:0] port_c_direction;
  logic [1:0] port_d_direction;
  logic [7:0] port_c_pulse_select;
  logic [7:0] sync_and_serial_select;
  logic [7:0] a_sync1, a_pin;
  logic [5:0] b_sync1, b_pin;
  logic [7:0] c_sync1, c_pin;
  logic [1:0] d_sync1, d_pin;
  logic [7:0] next_rdata;
  logic       in_block;
  logic [7:0] c_take, c_val, c_oe_n;
  logic       scl_take, sda_take;

  // Pins pass two flops before the read path sees them
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      a_sync1 <= 8'h00;
      b_sync1 <= 6'h00;
      c_sync1 <= 8'h00;
      d_sync1 <= 2'h3;                             // Pull-up idle level
      a_pin   <= 8'h00;
      b_pin   <= 6'h00;
      c_pin   <= 8'h00;
      d_pin   <= 2'h3;                             // No false serial edge
    end
    else
    begin
      a_sync1 <= port_a_in;
      b_sync1 <= port_b_in;
      c_sync1 <= port_c_in;
      d_sync1 <= port_d_in;
      a_pin   <= a_sync1;
      b_pin   <= b_sync1;
      c_pin   <= c_sync1;
      d_pin   <= d_sync1;
    end
  end

  // Latches load regardless of direction; no reset on purpose
  always_ff @(posedge clk_sys)
  begin
    if (reg_write)
    begin
      if (reg_addr == OFS_A_LATCH)
        port_a_latch <= reg_wdata;
      else if (reg_addr == OFS_B_LATCH)
        port_b_latch <= reg_wdata[5:0];
      else if (reg_addr == OFS_C_LATCH)
        port_c_latch <= reg_wdata;
      else if (reg_addr == OFS_D_LATCH)
        port_d_latch <= reg_wdata[1:0];
    end
  end

  // Direction and select registers, cleared by reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      port_a_direction       <= DIR_RESET;
      port_b_direction       <= DIR_RESET[5:0];
      port_c_direction       <= DIR_RESET;
      port_d_direction       <= DIR_RESET[1:0];
      port_c_pulse_select    <= CFG_RESET;
      sync_and_serial_select <= CFG_RESET;
    end
    else if (reg_write)
    begin
      if (reg_addr == OFS_A_DIR)
        port_a_direction <= reg_wdata;
      else if (reg_addr == OFS_B_DIR)
        port_b_direction <= reg_wdata[5:0];
      else if (reg_addr == OFS_C_DIR)
        port_c_direction <= reg_wdata;
      else if (reg_addr == OFS_D_DIR)
        port_d_direction <= reg_wdata[1:0];
      else if (reg_addr == OFS_PULSE_SEL)
        port_c_pulse_select <= reg_wdata;
      else if (reg_addr == OFS_SYNC_SEL)
        sync_and_serial_select <= {reg_wdata[7:6], 4'h0, reg_wdata[1:0]};
    end
  end

  // Read mux; per bit, latch when output, pin when input
  always_comb
  begin
    in_block   = (reg_addr < REG_BLOCK_END);
    next_rdata = READ_UNMAPPED;
    if (!in_block)
      next_rdata = READ_UNMAPPED;
    else if (reg_addr == OFS_A_LATCH)
      next_rdata = (port_a_direction & port_a_latch)
                 | (~port_a_direction & a_pin);
    else if (reg_addr == OFS_B_LATCH)
      next_rdata = {2'h0, (port_b_direction & port_b_latch)
                 | (~port_b_direction & b_pin)};
    else if (reg_addr == OFS_C_LATCH)
      next_rdata = (port_c_direction & port_c_latch)
                 | (~port_c_direction & c_pin);
    else if (reg_addr == OFS_D_LATCH)
      next_rdata = {6'h00, (port_d_direction & port_d_latch)
                 | (~port_d_direction & d_pin)};
    else if (reg_addr == OFS_A_DIR)
      next_rdata = port_a_direction;
    else if (reg_addr == OFS_B_DIR)
      next_rdata = {2'h0, port_b_direction};
    else if (reg_addr == OFS_C_DIR)
      next_rdata = port_c_direction;
    else if (reg_addr == OFS_D_DIR)
      next_rdata = {6'h00, port_d_direction};
    else if (reg_addr == OFS_PULSE_SEL)
      next_rdata = port_c_pulse_select;
    else if (reg_addr == OFS_SYNC_SEL)
      next_rdata = sync_and_serial_select;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // Port C sharing per pin; sync wins over pulse on the top two
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_port_c
      if (i == HSYNC_BIT || i == VSYNC_BIT)
      begin : g_sync
        logic sync_en, sync_val;
        assign sync_en  = sync_and_serial_select[i];
        assign sync_val = (i == HSYNC_BIT) ? horiz_sync_out : vert_sync_out;
        assign c_take[i] = sync_en | port_c_pulse_select[i];
        assign c_val[i]  = sync_en ? sync_val : pulse_out[i];
      end
      else
      begin : g_pulse
        assign c_take[i] = port_c_pulse_select[i];
        assign c_val[i]  = pulse_out[i];
      end
      assign c_oe_n[i] = c_take[i] ? 1'b0 : ~port_c_direction[i];
    end
  endgenerate

  // Port C outputs straight from latch or peripheral
  assign port_c_out  = (c_take & c_val) | (~c_take & port_c_latch);
  assign port_c_oe_n = c_oe_n;

  // Ports A and B follow direction alone
  assign port_a_out  = port_a_latch;
  assign port_a_oe_n = ~port_a_direction;
  assign port_b_out  = port_b_latch & PORT_B_MASK;
  assign port_b_oe_n = ~port_b_direction;

  // Serial lines ignore direction; they only ever pull low
  assign scl_take       = sync_and_serial_select[SCL_BIT];
  assign sda_take       = sync_and_serial_select[SDA_BIT];
  assign port_d_out[1]  = scl_take ? 1'b0 : port_d_latch[1];
  assign port_d_out[0]  = sda_take ? 1'b0 : port_d_latch[0];
  assign port_d_oe_n[1] = scl_take ? ~serial_clk_pull
                                   : ~port_d_direction[1];
  assign port_d_oe_n[0] = sda_take ? ~serial_data_pull
                                   : ~port_d_direction[0];
  assign serial_clk_in  = d_pin[1];
  assign serial_data_in = d_pin[0];

  // Reset state: every pin an input, nothing shared
  a_dir_reset_clear: assert property (
    @(posedge clk_sys)
    $rose(resetn)
    |-> (port_a_oe_n == 8'hff && port_c_oe_n == 8'hff))
    else $error("Pins not inputs after reset");
  a_bd_reset_clear: assert property (
    @(posedge clk_sys)
    $rose(resetn)
    |-> (port_b_oe_n == 6'h3f && port_d_oe_n == 2'h3))
    else $error("Ports B and D not inputs after reset");
  a_cfg_reset_zero: assert property (
    @(posedge clk_sys)
    $rose(resetn)
    |-> (port_c_pulse_select == CFG_RESET
         && sync_and_serial_select == CFG_RESET))
    else $error("Select registers not clear after reset");

  // Direction registers steer the pins and read back
  a_dir_readback: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_C_DIR)
    ##2 (reg_read && reg_addr == OFS_C_DIR)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Direction readback wrong");
  a_dir_readback_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_A_DIR)
    ##2 (reg_read && reg_addr == OFS_A_DIR)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Port A direction readback wrong");
  a_dir_sets_oe: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_A_DIR)
    |=> port_a_oe_n == ~$past(reg_wdata))
    else $error("Port A drive does not follow direction");
  a_b_dir_sets_oe: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_B_DIR)
    |=> port_b_oe_n == ~$past(reg_wdata[5:0]))
    else $error("Port B drive does not follow direction");
  a_input_write_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_A_LATCH && port_a_direction == 8'h00)
    |=> port_a_oe_n == 8'hff)
    else $error("Input pin driven after latch write");
  a_write_drives: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_A_LATCH)
    |=> port_a_out == $past(reg_wdata))
    else $error("Latch write not on pin");
  a_write_drives_b: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == OFS_B_LATCH && port_b_direction == 6'h3f)
    |=> (port_b_out == $past(reg_wdata[5:0]) && port_b_oe_n == 6'h00))
    else $error("Port B latch write not on pins");

  // Read path: latch for outputs, synced pin for inputs
  a_out_reads_latch: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read && reg_addr == OFS_A_LATCH && port_a_direction == 8'hff)
    |=> reg_rdata == $past(port_a_latch))
    else $error("Output read not latch");
  a_in_reads_pin: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read && reg_addr == OFS_A_LATCH && port_a_direction == 8'h00)
    |=> reg_rdata == $past(port_a_in, 3))
    else $error("Input read not pin");
  a_b_read_pin: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read && reg_addr == OFS_B_LATCH && port_b_direction == 6'h00)
    |=> reg_rdata == {2'h0, $past(port_b_in, 3)})
    else $error("Port B input read not pin");
  a_unmapped_zero: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read && reg_addr >= REG_BLOCK_END)
    |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  a_unmapped_gap: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (reg_read && reg_addr == 6'h08)
    |=> reg_rdata == READ_UNMAPPED)
    else $error("Gap read not zero");

  // Pin sharing; pulse and sync owners always drive their pin, serial owners drive only while pulling low
  a_sync_priority: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sync_and_serial_select[HSYNC_BIT]
    |-> (port_c_out[7] == horiz_sync_out && !port_c_oe_n[7]))
    else $error("Sync does not own pin 7");
  a_vsync_priority: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sync_and_serial_select[VSYNC_BIT]
    |-> (port_c_out[6] == vert_sync_out && !port_c_oe_n[6]))
    else $error("Sync does not own pin 6");
  a_pulse_top: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (port_c_pulse_select[7] && !sync_and_serial_select[HSYNC_BIT])
    |-> (port_c_out[7] == pulse_out[7] && !port_c_oe_n[7]))
    else $error("Pulse does not own pin 7 without sync");
  a_pulse_take: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    port_c_pulse_select[0]
    |-> (port_c_out[0] == pulse_out[0] && !port_c_oe_n[0]))
    else $error("Pulse does not own pin 0");
  a_pulse_pin3: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    port_c_pulse_select[3]
    |-> (port_c_out[3] == pulse_out[3] && !port_c_oe_n[3]))
    else $error("Pulse does not own pin 3");
  a_serial_drain: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    scl_take
    |-> (port_d_out[1] == 1'b0 && port_d_oe_n[1] == !serial_clk_pull))
    else $error("Serial clock not open drain");
  a_data_drain: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sda_take
    |-> (port_d_out[0] == 1'b0 && port_d_oe_n[0] == !serial_data_pull))
    else $error("Serial data not open drain");
endmodule : ppps_ports

/* sim/ppps_pin_model.sv */
// Purpose: Far side of the port pins, resolving each line's level.
// Assumes: The bench sets the level that external circuits apply.
// Notes:   Port D lines carry pull-ups, so the bench idles them high.
`timescale 1ns/1ps
module ppps_pin_model
(
  // Device drive
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe_n,
  input  wire logic [5:0] port_b_out,
  input  wire logic [5:0] port_b_oe_n,
  input  wire logic [7:0] port_c_out,
  input  wire logic [7:0] port_c_oe_n,
  input  wire logic [1:0] port_d_out,
  input  wire logic [1:0] port_d_oe_n,
  // External levels
  input  wire logic [7:0] ext_a,
  input  wire logic [5:0] ext_b,
  input  wire logic [7:0] ext_c,
  input  wire logic [1:0] ext_d,
  // Resolved pins
  output logic      [7:0] port_a_in,
  output logic      [5:0] port_b_in,
  output logic      [7:0] port_c_in,
  output logic      [1:0] port_d_in
);
  // A released line shows the outside level; an unknown latch stays hidden
  assign port_a_in = (port_a_oe_n & ext_a) | (~port_a_oe_n & port_a_out);
  assign port_b_in = (port_b_oe_n & ext_b) | (~port_b_oe_n & port_b_out);
  assign port_c_in = (port_c_oe_n & ext_c) | (~port_c_oe_n & port_c_out);
  // Open drain: a driven zero beats the pull-up
  assign port_d_in = (port_d_oe_n & ext_d) | (~port_d_oe_n & port_d_out);
endmodule : ppps_pin_model

/* sim/tb_top.sv */
// Purpose: Register-level test of the four shared ports.
// Assumes: Pin levels reach the reads after the two-flop sync.
// Notes:   Latches are not reset, so each is written before reads.
`timescale 1ns/1ps
module tb_top;
  import ppps_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata, port_a_out, port_a_oe_n, port_a_in;
  logic [7:0] port_c_out, port_c_oe_n, port_c_in;
  logic [5:0] port_b_out, port_b_oe_n, port_b_in;
  logic [1:0] port_d_out, port_d_oe_n, port_d_in;
  logic [7:0] pulse_out = 8'h00;
  logic [7:0] ext_a = 8'h00;
  logic [7:0] ext_c = 8'h00;
  logic [5:0] ext_b = 6'h00;
  logic [1:0] ext_d = 2'h3;
  logic       horiz_sync_out = 1'b0;
  logic       vert_sync_out = 1'b0;
  logic       serial_clk_pull = 1'b0;
  logic       serial_data_pull = 1'b0;
  logic       serial_clk_in, serial_data_in;
  int         mismatches = 0;
  int         checks_done = 0;
  int         cycles = 0;

  ppps_ports ppps_ports_i (.clk_sys, .resetn, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .port_a_in, .port_a_out,
    .port_a_oe_n, .port_b_in, .port_b_out, .port_b_oe_n, .port_c_in,
    .port_c_out, .port_c_oe_n, .port_d_in, .port_d_out, .port_d_oe_n,
    .pulse_out, .horiz_sync_out, .vert_sync_out, .serial_clk_pull,
    .serial_data_pull, .serial_clk_in, .serial_data_in);
  ppps_pin_model ppps_pin_model_i (.port_a_out, .port_a_oe_n, .port_b_out,
    .port_b_oe_n, .port_c_out, .port_c_oe_n, .port_d_out, .port_d_oe_n,
    .ext_a, .ext_b, .ext_c, .ext_d, .port_a_in, .port_b_in, .port_c_in,
    .port_d_in);

  // 20 ns period
  always #10 clk_sys = ~clk_sys;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // A hang is cut short far beyond the hundred or so cycles needed
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check(port_a_oe_n & port_c_oe_n & {port_b_oe_n, port_d_oe_n}, 8'hff);
    rd(OFS_SYNC_SEL, 8'h00);
    rd(OFS_PULSE_SEL, 8'h00);
    rd(OFS_C_DIR, 8'h00);
    wr(OFS_A_DIR, 8'ha5);
    rd(OFS_A_DIR, 8'ha5);
    wr(OFS_B_DIR, 8'hff);
    rd(OFS_B_DIR, 8'h3f);
    wr(OFS_B_LATCH, 8'hea);
    check({2'h0, port_b_out}, 8'h2a);
    ext_b <= 6'h2d;
    wr(OFS_B_DIR, 8'h00);
    repeat (2) @(posedge clk_sys);
    rd(OFS_B_LATCH, 8'h2d);
    wr(OFS_C_DIR, 8'hcf);
    rd(OFS_C_DIR, 8'hcf);
    wr(OFS_D_DIR, 8'hff);
    rd(OFS_D_DIR, 8'h03);
    // Input pins: writes only load the latch, reads see the pin
    ext_a <= 8'hc3;
    wr(OFS_A_DIR, 8'h00);
    wr(OFS_A_LATCH, 8'h3c);
    check(port_a_oe_n, 8'hff);
    rd(OFS_A_LATCH, 8'hc3);
    wr(OFS_A_DIR, 8'h0f);
    check({port_a_oe_n[7:4], port_a_out[3:0]}, 8'hfc);
    repeat (2) @(posedge clk_sys);
    rd(OFS_A_LATCH, 8'hcc);
    // Port C handed to pulse and sync outputs
    pulse_out <= 8'h5a;
    horiz_sync_out <= 1'b1;
    wr(OFS_PULSE_SEL, 8'hff);
    check(port_c_oe_n, 8'h00);
    check(port_c_out, 8'h5a);
    wr(OFS_SYNC_SEL, 8'hc0);
    check(port_c_out, 8'h9a);
    vert_sync_out <= 1'b1;
    wr(OFS_PULSE_SEL, 8'h0f);
    check(port_c_oe_n, 8'h30);
    check(port_c_out & 8'hcf, 8'hca);
    // Port D handed to the serial bus whatever its direction
    wr(OFS_D_LATCH, 8'h03);
    check(port_d_oe_n, 8'h00);
    wr(OFS_SYNC_SEL, 8'hc3);
    check(port_d_oe_n, 8'h03);
    serial_clk_pull <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({port_d_out[1], port_d_oe_n}, 8'h01);
    check({serial_clk_in, serial_data_in}, 8'h01);
    serial_data_pull <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({port_d_oe_n, serial_clk_in, serial_data_in}, 8'h00);
    rd(OFS_SYNC_SEL, 8'hc3);
    // Nothing answers outside the mapped places
    wr(6'h2f, 8'hff);
    wr(6'h30, 8'hff);
    rd(6'h2f, 8'h00);
    rd(6'h08, 8'h00);
    rd(OFS_A_DIR, 8'h0f);
    // Second reset keeps the latch, clears the rest
    wr(OFS_A_DIR, 8'hff);
    resetn <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(port_a_oe_n, 8'hff);
    resetn <= 1'b1;
    rd(OFS_SYNC_SEL, 8'h00);
    wr(OFS_A_DIR, 8'hff);
    rd(OFS_A_LATCH, 8'h3c);
    conclude();
  end
endmodule : tb_top
